// ### core/spf_decoder.sv
// Purpose: Float command decoder of a weighing terminal fieldbus interface.
// Assumes: Command, float and live data come from logic on mclk_in; no synchronisers.
// Notes: Commands queue in a FIFO and one is executed per interface update tick.
`timescale 1ns/1ns
module spf_decoder
    import spf_pkg::*;
#(
    parameter int UPDATE_TICKS = spf_pkg::UPDATE_CYCLES,
    parameter int RDEPTH = spf_pkg::ROT_DEPTH,
    parameter int QDEPTH = spf_pkg::FIFO_DEPTH
) (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic plc_valid_in,
    input spf_pkg::spf_cmd_type plc_word_in,
    output logic plc_ready_out,
    input spf_pkg::spf_live_type live_in,
    input wire logic scale_base_if_fitted_in,
    output spf_pkg::spf_rsp_type rsp_out,
    output spf_pkg::spf_fill_type fill_in_vals_out,
    output spf_pkg::spf_fill_type fill_out_vals_out,
    output spf_pkg::spf_cmp_type cmp_limits_out,
    output spf_pkg::spf_event_type event_out,
    output logic tare_inhibit_out,
    output spf_pkg::spf_msg_type msg_out,
    output logic [4:0] msg_len_limit_out
);
    import spf_pkg::*;
    localparam int PW = $clog2(RDEPTH);
    localparam int CW = $clog2(RDEPTH + 1);

    logic tick;
    logic head_valid;
    spf_cmd_type head;
    logic exec;
    logic busy;
    logic [15:0] cmd;
    logic [15:0] d_live, d_add, d_msg, d_fin, d_fout, d_frep, d_trig, d_cset, d_crep;
    logic is_rot_auto, is_step, is_rot_reset, is_live_rep, is_add, is_msg, is_tare;
    logic is_fin_set, is_fout_set, is_frep, is_fin_rot, is_fout_rot, is_trig;
    logic is_cset, is_crep, is_capply, is_load, is_rep, is_rotcmd, known, step_go;
    spf_src_type rep_src, load_src, rot_src, add_base;
    logic [31:0][31:0] all_src;
    spf_fill_type fin_r, fout_r;
    spf_cmp_type cmp_r;
    spf_src_type rot_list_r [RDEPTH];
    logic [CW-1:0] rot_cnt_r, ptr_inc;
    logic [PW-1:0] rot_ptr_r, ptr_adv;
    logic rot_step, add_go;
    int add_n;
    int cnt_sum;
    logic [15:0] last_cmd_r;
    spf_rsp_type rsp_r, rsp_nxt;
    spf_mode_type mode_r, mode_nxt;
    spf_src_type src_r, src_nxt;
    logic [1:0] ack_seq_r, ack_seq_nxt;
    spf_event_type event_r, event_nxt;
    logic [7:0] trig_hot;
    logic tare_inhibit_r;
    spf_msg_type msg_r;

    function automatic spf_ind_type ind_of(input spf_src_type s);
        return {s >= SRC_FIN_BASE, s};
    endfunction

    spf_tick #(.PERIOD(UPDATE_TICKS)) u_tick (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .tick_out(tick)
    );

    // The queue drains only on update ticks, so a fast writer sees back-pressure
    spf_fifo #(.WIDTH($bits(spf_cmd_type)), .DEPTH(QDEPTH)) u_fifo (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .in_valid_in(plc_valid_in),
        .in_data_in(plc_word_in),
        .in_ready_out(plc_ready_out),
        .out_valid_out(head_valid),
        .out_data_out(head),
        .out_ready_in(tick)
    );

    // Command class decode; unsigned offsets fold each range test into one compare
    // Exec needs a queued head, so unknown data in empty storage never acts
    assign exec = tick && head_valid;
    assign cmd = head.cmd;
    assign d_live = cmd - CMD_LIVE_REP;
    assign d_add = cmd - CMD_ROT_ADD;
    assign d_msg = cmd - CMD_MSG_CLEAR;
    assign d_fin = cmd - CMD_FIN_SET;
    assign d_fout = cmd - CMD_FOUT_SET;
    assign d_frep = cmd - CMD_FILL_REP;
    assign d_trig = cmd - CMD_TRIG;
    assign d_cset = cmd - CMD_CMP_SET;
    assign d_crep = cmd - CMD_CMP_REP;
    assign is_rot_auto = (cmd == CMD_ROT_AUTO);
    assign is_step = (cmd == CMD_STEP_A) || (cmd == CMD_STEP_B);
    assign is_rot_reset = (cmd == CMD_ROT_RESET);
    assign is_live_rep = (d_live < SPAN_LIVE);
    assign is_add = (d_add < SPAN_LIVE);
    assign is_msg = (d_msg < SPAN_MSG);
    assign is_tare = (cmd == CMD_TARE_OFF) || (cmd == CMD_TARE_ON);
    assign is_fin_set = (d_fin < SPAN_FILL);
    assign is_fout_set = (d_fout < SPAN_FILL);
    assign is_frep = (d_frep < SPAN_FILL_REP);
    assign is_fin_rot = (cmd == CMD_FIN_ROT);
    assign is_fout_rot = (cmd == CMD_FOUT_ROT);
    assign is_trig = (d_trig < SPAN_TRIG);
    assign is_cset = (d_cset < SPAN_CMP);
    assign is_crep = (d_crep < SPAN_CMP);
    assign is_capply = (cmd == CMD_CMP_APPLY);
    assign is_load = is_fin_set || is_fout_set || is_cset;
    assign is_rep = is_live_rep || is_frep || is_crep;
    assign is_rotcmd = is_rot_auto || is_step;
    assign known = is_rotcmd || is_rot_reset || is_rep || is_load || is_add || is_msg
        || is_tare || is_fin_rot || is_fout_rot || is_trig || is_capply;
    assign busy = exec && known;
    assign step_go = is_step && (cmd != last_cmd_r);

    // Source selection; fill-report ids follow fill-in then fill-out order
    assign rep_src = is_live_rep ? d_live[4:0] :
                     is_frep ? SRC_FIN_BASE + d_frep[4:0] :
                     SRC_CMP_BASE + d_crep[4:0];
    assign load_src = is_fin_set ? SRC_FIN_BASE + d_fin[4:0] :
                      is_fout_set ? SRC_FOUT_BASE + d_fout[4:0] :
                      SRC_CMP_BASE + d_cset[4:0];
    // Padding words keep an unused id from reading undefined data
    assign all_src = {{3{FLOAT_ZERO}}, cmp_r, fout_r, fin_r, live_in};
    assign rot_src = (rot_cnt_r == '0) ? SRC_GROSS : rot_list_r[rot_ptr_r];
    assign ptr_inc = CW'(rot_ptr_r) + CW'(1);
    assign ptr_adv = (ptr_inc >= rot_cnt_r) ? '0 : rot_ptr_r + PW'(1);

    // Rotation advances on command 0, on a 1/2 change, or each tick in auto mode
    assign rot_step = (busy && (is_rot_auto || step_go))
        || (tick && !busy && mode_r == MODE_ROT_AUTO);
    assign add_go = exec && (is_add || is_fin_rot || is_fout_rot);
    assign add_n = is_add ? 1 : FILL_N;
    assign add_base = is_add ? d_add[4:0] : (is_fin_rot ? SRC_FIN_BASE : SRC_FOUT_BASE);
    assign cnt_sum = int'(rot_cnt_r) + add_n;

    // Rotation list entries; full list silently drops further additions
    // No reset on entries: only slots below the count are ever read
    always_ff @(posedge mclk_in) begin
        for (int k = 0; k < FILL_N; k++) begin
            if (add_go && k < add_n && int'(rot_cnt_r) + k < RDEPTH) begin
                rot_list_r[int'(rot_cnt_r) + k] <= add_base + spf_src_type'(k);
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rot_cnt_r <= '0;
            rot_ptr_r <= '0;
        end else if (exec && is_rot_reset) begin
            rot_cnt_r <= '0;
            rot_ptr_r <= '0;
        end else if (add_go) begin
            rot_cnt_r <= (cnt_sum > RDEPTH) ? CW'(RDEPTH) : CW'(cnt_sum);
        end else if (rot_step) begin
            rot_ptr_r <= ptr_adv;
        end
    end

    // Stored set-points; only the matching load code writes them
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            fin_r <= '0;
            fout_r <= '0;
            cmp_r <= '0;
        end else if (exec) begin
            if (is_fin_set) fin_r[d_fin[2:0]] <= head.value;
            if (is_fout_set) fout_r[d_fout[2:0]] <= head.value;
            if (is_cset) cmp_r[d_cset[3:0]] <= head.value;
        end
    end

    // Response next value; an ignored code only lets the current mode refresh
    always_comb begin
        rsp_nxt = rsp_r;
        mode_nxt = mode_r;
        src_nxt = src_r;
        ack_seq_nxt = ack_seq_r;
        if (busy) begin
            if (is_rotcmd) begin
                rsp_nxt.ack = ACK_RESET;
            end else begin
                ack_seq_nxt = (ack_seq_r == ACK_LAST) ? ACK_FIRST : ack_seq_r + 2'h1;
                rsp_nxt.ack = ack_seq_nxt;
            end
            if (is_load) begin
                mode_nxt = MODE_FIXED;
                rsp_nxt.value = head.value;
                rsp_nxt.ind = ind_of(load_src);
            end else if (is_rep) begin
                mode_nxt = MODE_SOURCE;
                src_nxt = rep_src;
                rsp_nxt.value = all_src[rep_src];
                rsp_nxt.ind = ind_of(rep_src);
            end else if (is_rot_auto || step_go) begin
                mode_nxt = is_rot_auto ? MODE_ROT_AUTO : MODE_ROT_MAN;
                rsp_nxt.value = all_src[rot_src];
                rsp_nxt.ind = ind_of(rot_src);
            end else if (is_step) begin
                mode_nxt = MODE_ROT_MAN;
            end else begin
                mode_nxt = MODE_FIXED;
                rsp_nxt.value = FLOAT_ZERO;
                rsp_nxt.ind = IND_NONE;
            end
        end else if (tick) begin
            unique case (mode_r)
                MODE_SOURCE: begin
                    rsp_nxt.value = all_src[src_r];
                end
                MODE_ROT_AUTO: begin
                    rsp_nxt.value = all_src[rot_src];
                    rsp_nxt.ind = ind_of(rot_src);
                end
                MODE_FIXED: begin
                end
                MODE_ROT_MAN: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rsp_r <= '{value: FLOAT_ZERO, ind: IND_NONE, ack: ACK_RESET};
            mode_r <= MODE_FIXED;
            src_r <= SRC_GROSS;
            ack_seq_r <= ACK_RESET;
            last_cmd_r <= CMD_ROT_AUTO;
        end else begin
            rsp_r <= rsp_nxt;
            mode_r <= mode_nxt;
            src_r <= src_nxt;
            ack_seq_r <= ack_seq_nxt;
            if (exec) last_cmd_r <= cmd;
        end
    end

    // Trigger pulses last one cycle; the first two trigger codes drive the keypad fields
    assign trig_hot = (exec && is_trig) ? (8'h01 << d_trig[2:0]) : 8'h00;
    assign event_nxt = {exec && is_capply, trig_hot};

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            event_r <= '0;
            tare_inhibit_r <= 1'b0;
            msg_r <= '0;
        end else begin
            event_r <= event_nxt;
            if (exec && is_tare && scale_base_if_fitted_in) begin
                tare_inhibit_r <= (cmd == CMD_TARE_OFF);
            end
            if (exec && is_msg) begin
                msg_r.show <= (cmd != CMD_MSG_CLEAR);
                msg_r.message_index_field <= d_msg[2:0];
                if (cmd == CMD_PROMPT) msg_r.prompt_start_flag <= 1'b1;
                else if (cmd == CMD_MSG_CLEAR) msg_r.prompt_start_flag <= 1'b0;
            end
        end
    end

    assign rsp_out = rsp_r;
    assign fill_in_vals_out = fin_r;
    assign fill_out_vals_out = fout_r;
    assign cmp_limits_out = cmp_r;
    assign event_out = event_r;
    assign tare_inhibit_out = tare_inhibit_r;
    assign msg_out = msg_r;
    assign msg_len_limit_out = MSG_MAX_CHARS;

    // Checks next to the logic they guard
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);

    AST_FIN_LOAD: assert property (exec && is_fin_set |=>
        fin_r[$past(d_fin[2:0])] == $past(head.value)) else $error("fill-in load lost");
    AST_FOUT_LOAD: assert property (exec && is_fout_set |=>
        fout_r[$past(d_fout[2:0])] == $past(head.value)) else $error("fill-out load lost");
    AST_CMP_LOAD: assert property (exec && is_cset |=>
        cmp_r[$past(d_cset[3:0])] == $past(head.value)) else $error("limit load lost");
    AST_ECHO: assert property (busy && is_load |=> rsp_r.value == $past(head.value)
        && rsp_r.ack != ACK_RESET) else $error("load not echoed");
    AST_ACTION_ZERO: assert property (busy && !is_load && !is_rep && !is_rotcmd
        |=> rsp_r.value == FLOAT_ZERO && rsp_r.ind == IND_NONE) else $error("action not zero");
    AST_ROT_ACK: assert property (mode_r == MODE_ROT_AUTO || mode_r == MODE_ROT_MAN
        |-> rsp_r.ack == ACK_RESET) else $error("ack nonzero in rotation");
    AST_ZERO_GROSS: assert property (busy && is_rot_auto && rot_cnt_r == '0
        |=> rsp_r.value == $past(live_in[0]) && rsp_r.ind == 6'h00) else $error("no gross");
    AST_UNKNOWN: assert property (exec && !known |=> $stable(rsp_r.ack)
        && $stable(fin_r) && $stable(cmp_r) && $stable(rot_cnt_r)) else $error("unknown acted");
    AST_LIVE_REFRESH: assert property (tick && !busy && mode_r == MODE_SOURCE
        |=> rsp_r.value == $past(all_src[src_r])) else $error("report not refreshed");
    AST_STEP: assert property (busy && step_go && rot_cnt_r > CW'(1)
        |=> rot_ptr_r != $past(rot_ptr_r)) else $error("step did not advance");
    AST_PROMPT: assert property (exec && cmd == CMD_PROMPT |=>
        msg_r.prompt_start_flag && msg_r.message_index_field == 3'h6) else $error("no prompt");
    AST_TRIG_PULSE: assert property (event_r != '0 |=>
        event_r == '0) else $error("trigger stuck");
    // Gated tare, message fields and batch appends
    AST_TARE_GATE: assert property (exec && is_tare && !scale_base_if_fitted_in
        |=> $stable(tare_inhibit_r)) else $error("tare changed without interface");
    AST_MSG_INDEX: assert property (exec && is_msg |=>
        msg_r.message_index_field == $past(d_msg[2:0])) else $error("message index wrong");
    AST_MSG_CLEAR: assert property (exec && cmd == CMD_MSG_CLEAR |=>
        msg_r == '0) else $error("message not cleared");
    AST_ROT_ADD: assert property (exec && (is_fin_rot || is_fout_rot)
        && rot_cnt_r <= CW'(RDEPTH - FILL_N)
        |=> rot_cnt_r == $past(rot_cnt_r) + CW'(FILL_N)) else $error("fill values not added");

    COV_LOAD: cover property (busy && is_fin_set ##1 busy && is_frep);
    COV_ROT: cover property (tick && !busy && mode_r == MODE_ROT_AUTO && rot_cnt_r > CW'(1));
    COV_FULL: cover property (!plc_ready_out);
    COV_MSG: cover property (exec && cmd == CMD_PROMPT);
endmodule // spf_decoder

// ### core/spf_fifo.sv
// Purpose: Command FIFO between the fieldbus writer and the decoder.
// Assumes: DEPTH is a power of two.
// Notes: Head data is read straight from the storage flops.
`timescale 1ns/1ns
module spf_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 16
) (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0] wr_ptr_r;
    logic [AW:0] rd_ptr_r;
    logic push;
    logic pop;

    // Full when pointers differ only in the wrap bit
    assign in_ready_out = (wr_ptr_r != {~rd_ptr_r[AW], rd_ptr_r[AW-1:0]});
    assign out_valid_out = (wr_ptr_r != rd_ptr_r);
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = mem_r[rd_ptr_r[AW-1:0]];

    // Storage needs no reset, only pointers are control state
    always_ff @(posedge mclk_in) begin
        if (push) begin
            mem_r[wr_ptr_r[AW-1:0]] <= in_data_in;
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) wr_ptr_r <= wr_ptr_r + (AW+1)'(1);
            if (pop) rd_ptr_r <= rd_ptr_r + (AW+1)'(1);
        end
    end
endmodule // spf_fifo

// ### core/spf_tick.sv
// Purpose: Interface update tick, one pulse per update period.
// Assumes: Single clock, PERIOD of at least two cycles.
// Notes: Shorten PERIOD in simulation; the real period is millions of cycles.
`timescale 1ns/1ns
module spf_tick #(
    parameter int PERIOD = 6_000_000
) (
    input wire logic mclk_in,
    input wire logic rstn_in,
    output logic tick_out
);
    localparam int CW = $clog2(PERIOD);
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
    logic [CW-1:0] cnt_r;

    // Free-running divider, pulse on the last count
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + CW'(1);
        end
    end
    assign tick_out = (cnt_r == LAST);
endmodule // spf_tick

// ### dv/spf_plc_model.sv
// Purpose: Fieldbus master model that writes command words into the decoder.
// Assumes: Back-to-back sends are legal; the queue's ready paces them.
// Notes: Released lines show the inverse word, so a stale value never passes as fresh.
`timescale 1ns/1ns
module spf_plc_model
    import spf_pkg::*;
(
    input wire logic mclk_in,
    input wire logic ready_in,
    output logic valid_out,
    output spf_pkg::spf_cmd_type word_out,
    output logic stuck_out
);
    initial begin
        valid_out = 1'b0;
        word_out = '0;
        stuck_out = 1'b0;
    end
    // Hold the word until the queue takes it; ready only moves on clock edges
    task automatic send(input logic [15:0] code, input spf_float_type val);
        int n;
        n = 0;
        @(posedge mclk_in);
        #1;
        valid_out = 1'b1;
        word_out = {code, val}; // Float sits beside the code
        while (!ready_in && n < 200) begin
            @(posedge mclk_in);
            #1;
            n++;
        end
        @(posedge mclk_in);
        stuck_out = (n >= 200);
        #1;
        valid_out = 1'b0;
        word_out = ~word_out;
    endtask
endmodule // spf_plc_model

// ### dv/testbench.sv
// Purpose: Self-checking bench of the float command decoder.
// Assumes: Update period shortened to 8 cycles; one command per update.
// Notes: Each scenario waits a full update so the response has settled.
`timescale 1ns/1ns
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module testbench;
    import spf_pkg::*;
    localparam int TK = 8;
    logic mclk_in, rstn_in, plc_valid_in, plc_ready_out, stuck;
    spf_cmd_type plc_word_in;
    spf_live_type live_in;
    spf_rsp_type rsp_out;
    spf_fill_type fin, fout;
    spf_cmp_type cmp;
    spf_event_type event_out, ev_seen;
    spf_msg_type msg_out;
    logic tare_inh, fitted;
    logic [4:0] len_lim;
    int bad_count = 0;
    int checked = 0;
    spf_plc_model plc_u (.mclk_in(mclk_in), .ready_in(plc_ready_out), .valid_out(plc_valid_in),
        .word_out(plc_word_in), .stuck_out(stuck));
    spf_decoder #(.UPDATE_TICKS(TK)) dut_u (.mclk_in(mclk_in), .rstn_in(rstn_in),
        .plc_valid_in(plc_valid_in), .plc_word_in(plc_word_in), .plc_ready_out(plc_ready_out),
        .live_in(live_in), .scale_base_if_fitted_in(fitted), .rsp_out(rsp_out),
        .fill_in_vals_out(fin), .fill_out_vals_out(fout), .cmp_limits_out(cmp),
        .event_out(event_out), .tare_inhibit_out(tare_inh), .msg_out(msg_out),
        .msg_len_limit_out(len_lim));
    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end
    task automatic report_and_stop();
        $display("counts: checked %0d bad %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // One command, then a full update for it to execute; events are gathered
    task automatic run(input logic [15:0] c, input spf_float_type v);
        plc_u.send(c, v);
        if (stuck === 1'b1) begin bad_count++; report_and_stop(); end
        ev_seen = '0;
        repeat (TK + 2) begin // Next command only after the answer
            @(posedge mclk_in);
            #1;
            ev_seen = ev_seen | event_out;
        end
    endtask
    task automatic t_fill();
        for (int i = 0; i < 10; i++) begin
            run(16'd170 + 16'(i), 32'h4000_0000 + i);
            `CHK("echo", 32'h4000_0000 + i, rsp_out.value)
            `CHK("ind", 6'h29 + 6'(i), rsp_out.ind)
            `CHK("ack", 2'(i % 3 + 1), rsp_out.ack)
            `CHK("store", 32'h4000_0000 + i, (i < 5) ? fin[i] : fout[i-5])
        end
        for (int i = 0; i < 10; i++) begin
            run(16'd180 + 16'(i), 32'h0000_0000);
            `CHK("report", 32'h4000_0000 + i, rsp_out.value)
        end
        $display("test fill done");
    endtask
    task automatic t_cmp();
        for (int i = 0; i < 10; i++) begin
            run(16'd210 + 16'(i), 32'h4100_0000 + i);
            `CHK("limit", 32'h4100_0000 + i, cmp[i])
            run(16'd222 + 16'(i), 32'h0000_0000);
            `CHK("limit report", 32'h4100_0000 + i, rsp_out.value)
        end
        run(16'd232, 32'h0000_0000);
        `CHK("apply", 9'h100, ev_seen)
        $display("test cmp done");
    endtask
    task automatic t_act();
        logic [1:0] a;
        for (int i = 0; i < 8; i++) begin
            run(16'd192 + 16'(i), 32'h1234_5678);
            `CHK("event", 9'h001 << i, ev_seen)
            `CHK("zero", 32'h0000_0000, rsp_out.value)
        end
        run(16'd162, 32'h0000_0000);
        `CHK("tare off", 1'b1, tare_inh)
        run(16'd163, 32'h0000_0000);
        `CHK("tare on", 1'b0, tare_inh)
        run(16'd86, 32'h0000_0000);
        `CHK("prompt", 5'h1D, msg_out)
        `CHK("len", 5'h14, len_lim)
        run(16'd80, 32'h0000_0000);
        `CHK("clear", 5'h00, msg_out)
        a = rsp_out.ack;
        run(16'd220, 32'hDEAD_BEEF);
        `CHK("ack kept", a, rsp_out.ack)
        `CHK("kept", 32'h4000_0000, fin[0])
        `CHK("value kept", 32'h0000_0000, rsp_out.value)
        run(16'd83, '0);
        `CHK("slot", 5'h16, msg_out)
        $display("test act done");
    endtask
    // Gross then rate, one field per update, acknowledge held at zero
    task automatic t_rot();
        int n;
        run(16'd3, 32'h0000_0000);
        run(16'd40, 32'h0000_0000);
        run(16'd46, 32'h0000_0000);
        plc_u.send(16'd0, 32'h0000_0000);
        n = 0;
        while (rsp_out.ind !== 6'h00 && n < 3 * TK) begin
            @(posedge mclk_in);
            #1;
            n++;
        end
        if (n >= 3 * TK) begin bad_count++; report_and_stop(); end
        `CHK("gross", live_in[0], rsp_out.value)
        `CHK("ack", 2'h0, rsp_out.ack)
        repeat (TK) @(posedge mclk_in);
        #1;
        `CHK("rate ind", 6'h06, rsp_out.ind)
        `CHK("rate", live_in[6], rsp_out.value)
        $display("test rot done");
    endtask
    // Burst of ignored codes fills the queue; all are consumed with no effect
    task automatic t_full();
        logic [1:0] a;
        logic low_seen;
        a = rsp_out.ack;
        low_seen = 1'b0;
        for (int i = 0; i < 28; i++) begin
            plc_u.send(16'd221, '0);
            if (stuck === 1'b1) begin bad_count++; report_and_stop(); end
            low_seen = low_seen | !plc_ready_out;
        end
        repeat (17 * TK) @(posedge mclk_in);
        #1;
        `CHK("full seen", 1'b1, low_seen)
        `CHK("drained", 1'b1, plc_ready_out)
        `CHK("ack kept", a, rsp_out.ack)
        $display("test full done");
    endtask
    // String live field, its refresh, and the tare-off code without the interface
    task automatic t_live();
        run(16'd18, '0);
        `CHK("string", 32'h3F80_0008, rsp_out.value)
        `CHK("string ind", 6'h08, rsp_out.ind)
        live_in[8] = 32'h4142_4344;
        repeat (TK) @(posedge mclk_in);
        #1;
        `CHK("refresh", 32'h4142_4344, rsp_out.value)
        fitted = 1'b0;
        run(16'd162, '0);
        `CHK("tare unfitted", 1'b0, tare_inh)
        fitted = 1'b1;
        $display("test live done");
    endtask
    // Manual stepping by alternating 1 and 2, then a fill-out batch in the list
    task automatic t_step();
        run(16'd3, '0);
        run(16'd40, '0);
        run(16'd46, '0);
        run(16'd1, '0);
        `CHK("step gross", 6'h00, rsp_out.ind)
        `CHK("step ack", 2'h0, rsp_out.ack)
        run(16'd2, '0);
        `CHK("step rate", 6'h06, rsp_out.ind)
        run(16'd2, '0);
        `CHK("step hold", 6'h06, rsp_out.ind)
        run(16'd191, '0);
        for (int i = 0; i < 3; i++) run(16'd2 - 16'(i % 2), '0);
        `CHK("fout ind", 6'h2E, rsp_out.ind)
        `CHK("fout value", 32'h4000_0005, rsp_out.value)
        $display("test step done");
    endtask
    initial begin
        #(100000 * 10);
        bad_count++;
        report_and_stop();
    end
    initial begin
        rstn_in = 1'b0;
        fitted = 1'b1;
        for (int i = 0; i < 9; i++) live_in[i] = 32'h3F80_0000 + 32'(i);
        repeat (16) @(posedge mclk_in);
        #1;
        rstn_in = 1'b1;
        t_fill();
        t_cmp();
        t_act();
        t_full();
        t_live();
        t_rot();
        t_step();
        report_and_stop();
    end
endmodule // testbench

// ### pkg/spf_pkg.sv
// Purpose: Shared constants and types of the float command decoder.
// Assumes: 16-bit command word and 32-bit float arrive together from the fieldbus side.
// Notes: Source ids 0..8 are live data, 9..28 are values held in the decoder.
package spf_pkg;
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int UPDATE_PERIOD_MS = 60;
    localparam int UPDATE_CYCLES = UPDATE_PERIOD_MS * 1_000_000 / CLK_PERIOD_NS;
    localparam int PLC_SCAN_MS = 30;
    // Sizes
    localparam int FILL_N = 5;
    localparam int CMP_N = 10;
    localparam int LIVE_N = 9;
    localparam int ROT_DEPTH = 16;
    localparam int FIFO_DEPTH = 16;
    localparam logic [4:0] MSG_MAX_CHARS = 5'h14;
    // Command codes
    localparam logic [15:0] CMD_ROT_AUTO = 16'h0000;
    localparam logic [15:0] CMD_STEP_A = 16'h0001;
    localparam logic [15:0] CMD_STEP_B = 16'h0002;
    localparam logic [15:0] CMD_ROT_RESET = 16'h0003;
    localparam logic [15:0] CMD_LIVE_REP = 16'h000A;
    localparam logic [15:0] CMD_ROT_ADD = 16'h0028;
    localparam logic [15:0] CMD_MSG_CLEAR = 16'h0050;
    localparam logic [15:0] CMD_PROMPT = 16'h0056;
    localparam logic [15:0] CMD_TARE_OFF = 16'h00A2;
    localparam logic [15:0] CMD_TARE_ON = 16'h00A3;
    localparam logic [15:0] CMD_FIN_SET = 16'h00AA;
    localparam logic [15:0] CMD_FOUT_SET = 16'h00AF;
    localparam logic [15:0] CMD_FILL_REP = 16'h00B4;
    localparam logic [15:0] CMD_FIN_ROT = 16'h00BE;
    localparam logic [15:0] CMD_FOUT_ROT = 16'h00BF;
    localparam logic [15:0] CMD_TRIG = 16'h00C0;
    localparam logic [15:0] CMD_CMP_SET = 16'h00D2;
    localparam logic [15:0] CMD_CMP_REP = 16'h00DE;
    localparam logic [15:0] CMD_CMP_APPLY = 16'h00E8;
    // Code spans of the ranged commands
    localparam logic [15:0] SPAN_LIVE = 16'h0009;
    localparam logic [15:0] SPAN_MSG = 16'h0008;
    localparam logic [15:0] SPAN_FILL = 16'h0005;
    localparam logic [15:0] SPAN_FILL_REP = 16'h000A;
    localparam logic [15:0] SPAN_TRIG = 16'h0008;
    localparam logic [15:0] SPAN_CMP = 16'h000A;
    // Source ids and indication codes
    localparam logic [4:0] SRC_GROSS = 5'h00;
    localparam logic [4:0] SRC_FIN_BASE = 5'h09;
    localparam logic [4:0] SRC_FOUT_BASE = 5'h0E;
    localparam logic [4:0] SRC_CMP_BASE = 5'h13;
    localparam logic [5:0] IND_NONE = 6'h1E;
    // Reset values and acknowledge sequence bounds
    localparam logic [1:0] ACK_RESET = 2'h0;
    localparam logic [1:0] ACK_FIRST = 2'h1;
    localparam logic [1:0] ACK_LAST = 2'h3;
    localparam logic [31:0] FLOAT_ZERO = 32'h0000_0000;

    typedef logic [31:0] spf_float_type;
    typedef logic [4:0] spf_src_type;
    typedef logic [5:0] spf_ind_type;
    typedef logic [LIVE_N-1:0][31:0] spf_live_type;
    typedef logic [FILL_N-1:0][31:0] spf_fill_type;
    typedef logic [CMP_N-1:0][31:0] spf_cmp_type;
    typedef enum logic [1:0] {
        MODE_FIXED = 2'b00,
        MODE_SOURCE = 2'b01,
        MODE_ROT_AUTO = 2'b10,
        MODE_ROT_MAN = 2'b11
    } spf_mode_type;
    typedef struct packed {
        logic [15:0] cmd;
        spf_float_type value;
    } spf_cmd_type;
    typedef struct packed {
        spf_float_type value;
        spf_ind_type ind;
        logic [1:0] ack;
    } spf_rsp_type;
    typedef struct packed {
        logic cmp_apply;
        logic fout_abort;
        logic fout_resume;
        logic fout_pause;
        logic fin_abort;
        logic fin_resume;
        logic fin_pause;
        logic enter_key_trigger_field;
        logic confirm_key_trigger_field;
    } spf_event_type;
    typedef struct packed {
        logic show;
        logic [2:0] message_index_field;
        logic prompt_start_flag;
    } spf_msg_type;
endpackage
